// >>> src/pcpt_pkg.sv
// constants, register map and carriers for the loop control and periodic timer block
package pcpt_pkg;

    // register indices; the byte address on the bus is four times the index
    localparam logic [5:0] LOOP_CONTROL_IDX = 6'h06;
    localparam logic [5:0] PERIODIC_RATE_IDX = 6'h07;
    localparam logic [5:0] TIMER_STATUS_IDX = 6'h10;

    // loop_control field positions
    localparam int MONITOR_EN_BIT = 7;
    localparam int LOOP_ON_BIT = 6;
    localparam int AUTO_BIT = 5;
    localparam int ACQUIRE_BIT = 4;
    localparam int PRE_BIT = 2;
    localparam int WATCHDOG_PS_BIT = 1;
    localparam int FALLBACK_EN_BIT = 0;

    // periodic_rate_control field positions
    localparam int RATE_PRESCALE_HI = 6;
    localparam int RATE_PRESCALE_LO = 4;
    localparam int RATE_MODULUS_HI = 3;
    localparam int RATE_MODULUS_LO = 0;

    // timer_status field positions
    localparam int STAT_FLAG_BIT = 0;
    localparam int STAT_SELF_CLOCK_BIT = 1;

    // values after reset
    localparam logic [7:0] LOOP_CONTROL_RST = 8'hf1;
    localparam logic [6:0] PERIODIC_RATE_RST = 7'h00;

    // prescale code 001 divides by two to the power PRESCALE_EXP_BASE plus one
    localparam int PRESCALE_EXP_BASE = 9;
    localparam int PRESCALE_W = 16;
    localparam int MODULUS_W = 4;
    localparam logic [2:0] PRESCALE_OFF = 3'h0;

    // classic wishbone request as seen by the slave
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } pcpt_wb_req_t;

    // operating mode of the chip as seen by this block
    typedef struct packed {
        logic stop_mode;
        logic wait_mode;
        logic special_mode;
        logic pseudo_stop_select;
        logic loop_clock_select;
        logic loop_stop_in_wait;
        logic periodic_timer_stop_in_wait;
        logic watchdog_stop_in_wait;
    } pcpt_mode_t;

endpackage

// >>> src/pcpt_core.sv
// loop control bits, clock monitor and self-clock logic, periodic interrupt timer
// How it works
// - clock monitor enable writes are dropped while self-clock mode is active.
// - enabled monitor reacts to slow oscillator with monitor reset or self-clock.
// - full stop without pseudo-stop disables the clock monitor regardless of enable.
// - loop power follows its on bit, but is off in wait with stop-in-wait; writes ignored while loop clock selected.
// - self-clock keeps the loop powered; the on bit still reads its stored value.
// - loop on with automatic bandwidth locks by itself.
// - automatic bandwidth writes ignored while stop-in-wait forces it to one.
// - automatic picks mode from target proximity; otherwise acquisition bit decides.
// - acquisition bit zero selects low bandwidth, one selects high bandwidth.
// - periodic timer runs in pseudo-stop only with its pseudo-stop enable.
// - periodic timer stopped in pseudo-stop holds its dividers.
// - watchdog counts in pseudo-stop only with its pseudo-stop enable.
// - watchdog stopped in pseudo-stop freezes its dividers, no reinitialise.
// - fallback enable writes once in normal modes, anytime in special, never cleared in self-clock.
// - clock failure enters self-clock if fallback enabled, else monitor reset.
// - periodic rate register sits at index 7, readable and writable anytime.
// - any write to the rate register restarts the periodic counter.
// - prescale 000 is off, 001 to 111 divide by 2^10 to 2^16.
// - total period is modulus field plus one times the prescale count.
// - prescaler and modulus counter run on the oscillator clock.
// - prescale 000 keeps the timer off, and is the reset value.
// - pseudo-stop keeps oscillator at low amplitude; plain stop disables it.
module pcpt_core
    import pcpt_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire pcpt_wb_req_t wb_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire pcpt_mode_t mode_i,
    input wire logic osc_slow_i,
    input wire logic target_near_i,
    output logic clock_monitor_active_o,
    output logic monitor_reset_o,
    output logic self_clock_active_o,
    output logic oscillator_enable_o,
    output logic oscillator_low_amplitude_o,
    output logic loop_power_o,
    output logic loop_auto_lock_o,
    output logic loop_high_bandwidth_o,
    output logic periodic_run_o,
    output logic periodic_tick_o,
    output logic periodic_flag_o,
    output logic watchdog_run_o,
    output logic watchdog_init_o
);

    typedef struct packed {
        logic clock_monitor_enable;
        logic loop_power_on;
        logic auto_bandwidth;
        logic acquisition_select;
        logic periodic_pseudo_stop_enable;
        logic watchdog_pseudo_stop_enable;
        logic self_clock_fallback_enable;
        logic fallback_written;
        logic self_clock_active;
        logic monitor_reset;
        logic [6:0] periodic_rate_field;
        logic [PRESCALE_W-1:0] prescale_cnt;
        logic [MODULUS_W-1:0] modulus_cnt;
        logic periodic_tick;
        logic periodic_flag;
        logic ack;
        logic [7:0] rdata;
    } pcpt_state_t;

    pcpt_state_t s;
    pcpt_state_t next_s;

    logic req;
    logic wr;
    logic [5:0] idx;
    logic [7:0] wdata;
    logic pseudo_stop;
    logic full_stop;
    logic monitor_on;
    logic clock_fail;
    logic [2:0] prescale;
    logic [MODULUS_W-1:0] modulus;
    logic [16:0] prescale_span;
    logic [PRESCALE_W-1:0] prescale_last;
    logic timer_clear;
    logic timer_hold;
    logic loop_power;

    always_comb begin
        req = wb_i.cyc && wb_i.stb;
        // a write lands on the edge where the master sees ack
        wr = req && wb_i.we && s.ack && wb_i.sel[0];
        idx = wb_i.adr[7:2];
        wdata = wb_i.dat[7:0];
        pseudo_stop = mode_i.stop_mode && mode_i.pseudo_stop_select;
        full_stop = mode_i.stop_mode && !mode_i.pseudo_stop_select;
        monitor_on = s.clock_monitor_enable && !full_stop;
        clock_fail = monitor_on && osc_slow_i;
        prescale = s.periodic_rate_field[RATE_PRESCALE_HI:RATE_PRESCALE_LO];
        modulus = s.periodic_rate_field[RATE_MODULUS_HI:RATE_MODULUS_LO];
        // span is 2^(base+code); fits 17 bits for code 7
        prescale_span = 17'h00001 << (PRESCALE_EXP_BASE + 32'(prescale));
        prescale_last = PRESCALE_W'(prescale_span - 17'h00001);
        // off and wait-mode stop reinitialise; pseudo-stop only holds
        timer_clear = (prescale == PRESCALE_OFF)
            || (mode_i.wait_mode && mode_i.periodic_timer_stop_in_wait);
        timer_hold = pseudo_stop && !s.periodic_pseudo_stop_enable;
        loop_power = (s.loop_power_on
            && !(mode_i.wait_mode && mode_i.loop_stop_in_wait)) || s.self_clock_active;
    end

    always_comb begin
        next_s = s;
        next_s.periodic_tick = 1'b0;
        // registered ack: one wait state, drops the cycle after
        next_s.ack = req && !s.ack;
        next_s.rdata = 8'h00;
        if (req && !s.ack) begin
            case (idx)
                LOOP_CONTROL_IDX: begin
                    next_s.rdata[MONITOR_EN_BIT] = s.clock_monitor_enable;
                    next_s.rdata[LOOP_ON_BIT] = s.loop_power_on;
                    next_s.rdata[AUTO_BIT] = s.auto_bandwidth;
                    next_s.rdata[ACQUIRE_BIT] = s.acquisition_select;
                    next_s.rdata[PRE_BIT] = s.periodic_pseudo_stop_enable;
                    next_s.rdata[WATCHDOG_PS_BIT] = s.watchdog_pseudo_stop_enable;
                    next_s.rdata[FALLBACK_EN_BIT] = s.self_clock_fallback_enable;
                end
                PERIODIC_RATE_IDX: begin
                    next_s.rdata = {1'b0, s.periodic_rate_field};
                end
                TIMER_STATUS_IDX: begin
                    next_s.rdata[STAT_FLAG_BIT] = s.periodic_flag;
                    next_s.rdata[STAT_SELF_CLOCK_BIT] = s.self_clock_active;
                end
                default: begin
                    next_s.rdata = 8'h00;
                end
            endcase
        end

        // periodic timer on the oscillator clock, which is clk_i here
        if (timer_clear) begin
            next_s.prescale_cnt = '0;
            next_s.modulus_cnt = '0;
        end else if (!timer_hold) begin
            if (s.prescale_cnt == prescale_last) begin
                next_s.prescale_cnt = '0;
                if (s.modulus_cnt == modulus) begin
                    next_s.modulus_cnt = '0;
                    next_s.periodic_tick = 1'b1;
                end else begin
                    next_s.modulus_cnt = s.modulus_cnt + 4'h1;
                end
            end else begin
                next_s.prescale_cnt = s.prescale_cnt + 16'h0001;
            end
        end

        // stop-in-wait forces automatic bandwidth on
        if (mode_i.loop_stop_in_wait) begin
            next_s.auto_bandwidth = 1'b1;
        end

        if (wr) begin
            case (idx)
                LOOP_CONTROL_IDX: begin
                    if (!s.self_clock_active) begin
                        next_s.clock_monitor_enable = wdata[MONITOR_EN_BIT];
                    end
                    if (!mode_i.loop_clock_select) begin
                        next_s.loop_power_on = wdata[LOOP_ON_BIT];
                    end
                    if (!mode_i.loop_stop_in_wait) begin
                        next_s.auto_bandwidth = wdata[AUTO_BIT];
                    end
                    next_s.acquisition_select = wdata[ACQUIRE_BIT];
                    next_s.periodic_pseudo_stop_enable = wdata[PRE_BIT];
                    next_s.watchdog_pseudo_stop_enable = wdata[WATCHDOG_PS_BIT];
                    if (mode_i.special_mode || !s.fallback_written) begin
                        next_s.self_clock_fallback_enable = wdata[FALLBACK_EN_BIT]
                            || (s.self_clock_active && s.self_clock_fallback_enable);
                        next_s.fallback_written = 1'b1;
                    end
                end
                PERIODIC_RATE_IDX: begin
                    next_s.periodic_rate_field = wdata[6:0];
                    next_s.prescale_cnt = '0;
                    next_s.modulus_cnt = '0;
                    next_s.periodic_tick = 1'b0;
                end
                TIMER_STATUS_IDX: begin
                    if (wdata[STAT_FLAG_BIT]) begin
                        next_s.periodic_flag = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // a tick in the clearing cycle wins over the clear
        if (next_s.periodic_tick) begin
            next_s.periodic_flag = 1'b1;
        end

        // self-clock entry on failure, leave once the oscillator is back
        if (clock_fail && s.self_clock_fallback_enable) begin
            next_s.self_clock_active = 1'b1;
        end else if (!osc_slow_i) begin
            next_s.self_clock_active = 1'b0;
        end
        next_s.monitor_reset = clock_fail && !s.self_clock_fallback_enable
            && !s.self_clock_active;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
            s.clock_monitor_enable <= LOOP_CONTROL_RST[MONITOR_EN_BIT];
            s.loop_power_on <= LOOP_CONTROL_RST[LOOP_ON_BIT];
            s.auto_bandwidth <= LOOP_CONTROL_RST[AUTO_BIT];
            s.acquisition_select <= LOOP_CONTROL_RST[ACQUIRE_BIT];
            s.periodic_pseudo_stop_enable <= LOOP_CONTROL_RST[PRE_BIT];
            s.watchdog_pseudo_stop_enable <= LOOP_CONTROL_RST[WATCHDOG_PS_BIT];
            s.self_clock_fallback_enable <= LOOP_CONTROL_RST[FALLBACK_EN_BIT];
            s.periodic_rate_field <= PERIODIC_RATE_RST;
        end else begin
            s <= next_s;
        end
    end

    assign wb_ack_o = s.ack;
    assign wb_dat_o = {24'h000000, s.rdata};
    assign clock_monitor_active_o = monitor_on;
    assign monitor_reset_o = s.monitor_reset;
    assign self_clock_active_o = s.self_clock_active;
    // pseudo-stop trades a little power for faster, gentler stop recovery
    assign oscillator_enable_o = !full_stop;
    assign oscillator_low_amplitude_o = pseudo_stop;
    assign loop_power_o = loop_power;
    assign loop_auto_lock_o = loop_power && s.auto_bandwidth;
    assign loop_high_bandwidth_o = s.auto_bandwidth ? !target_near_i
        : s.acquisition_select;
    assign periodic_run_o = !timer_clear && !timer_hold;
    assign periodic_tick_o = s.periodic_tick;
    assign periodic_flag_o = s.periodic_flag;
    assign watchdog_run_o = !(mode_i.wait_mode && mode_i.watchdog_stop_in_wait)
        && !(pseudo_stop && !s.watchdog_pseudo_stop_enable);
    assign watchdog_init_o = mode_i.wait_mode && mode_i.watchdog_stop_in_wait;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    monitor_en_locked_a: assert property (
        s.self_clock_active && wr && idx == LOOP_CONTROL_IDX
        |=> $stable(s.clock_monitor_enable))
        else $error("monitor enable changed during self-clock");

    full_stop_mon_a: assert property (
        full_stop |-> !clock_monitor_active_o)
        else $error("monitor active in full stop");

    loop_on_locked_a: assert property (
        mode_i.loop_clock_select && wr && idx == LOOP_CONTROL_IDX
        |=> $stable(s.loop_power_on))
        else $error("loop on bit written while loop clock selected");

    self_clock_power_a: assert property (
        s.self_clock_active |-> loop_power_o)
        else $error("loop unpowered in self-clock");

    auto_forced_a: assert property (
        mode_i.loop_stop_in_wait |=> s.auto_bandwidth)
        else $error("automatic bandwidth not forced");

    bandwidth_sel_a: assert property (
        !s.auto_bandwidth |-> loop_high_bandwidth_o == s.acquisition_select)
        else $error("manual bandwidth mismatch");

    pseudo_hold_a: assert property (
        timer_hold && !timer_clear && !wr
        |=> $stable(s.prescale_cnt) && $stable(s.modulus_cnt))
        else $error("periodic dividers moved in pseudo-stop");

    fail_path_a: assert property (
        clock_fail && !s.self_clock_fallback_enable && !s.self_clock_active
        |=> monitor_reset_o && !self_clock_active_o)
        else $error("missing monitor reset");

    fail_fallback_a: assert property (
        clock_fail && s.self_clock_fallback_enable |=> self_clock_active_o && !monitor_reset_o)
        else $error("missing self-clock entry");

    rate_restart_a: assert property (
        wr && idx == PERIODIC_RATE_IDX |=> s.prescale_cnt == '0 && s.modulus_cnt == '0)
        else $error("rate write did not restart counter");

    off_quiet_a: assert property (
        prescale == PRESCALE_OFF |=> !periodic_tick_o)
        else $error("tick while timer off");

    shortest_period_a: assert property (
        periodic_tick_o && s.periodic_rate_field == 7'h10 && !timer_hold
        && !timer_clear && !wr |=> !periodic_tick_o [*8])
        else $error("period too short");

    flag_set_a: assert property (
        periodic_tick_o |-> periodic_flag_o)
        else $error("tick without flag");

    ack_pulse_a: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    ack_answer_a: assert property (
        wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged");

    rate_readback_a: assert property (
        wb_ack_o && !wb_i.we && idx == PERIODIC_RATE_IDX
        |-> wb_dat_o[7:0] == {1'b0, $past(s.periodic_rate_field)})
        else $error("rate register read back wrong");

    fallback_kept_a: assert property (
        s.self_clock_active && s.self_clock_fallback_enable
        |=> s.self_clock_fallback_enable)
        else $error("fallback enable cleared in self-clock");

    fallback_once_a: assert property (
        !mode_i.special_mode && s.fallback_written && wr && idx == LOOP_CONTROL_IDX
        |=> $stable(s.self_clock_fallback_enable))
        else $error("fallback enable rewritten in normal mode");

    monitor_quiet_a: assert property (
        !clock_monitor_active_o && !s.self_clock_active
        |=> !monitor_reset_o && !self_clock_active_o)
        else $error("failure reaction with monitor off");

    loop_off_a: assert property (
        !s.loop_power_on && !s.self_clock_active |-> !loop_power_o)
        else $error("loop powered while off");

    auto_track_a: assert property (
        s.auto_bandwidth |-> loop_high_bandwidth_o == !target_near_i)
        else $error("automatic bandwidth choice wrong");

    low_bandwidth_a: assert property (
        !s.auto_bandwidth && !s.acquisition_select |-> !loop_high_bandwidth_o)
        else $error("high bandwidth without acquisition");

    pseudo_run_a: assert property (
        pseudo_stop && s.periodic_pseudo_stop_enable && prescale != PRESCALE_OFF
        && !mode_i.wait_mode |-> periodic_run_o)
        else $error("periodic timer stopped in pseudo-stop");

    wait_clear_a: assert property (
        mode_i.wait_mode && mode_i.periodic_timer_stop_in_wait
        |=> s.prescale_cnt == '0 && s.modulus_cnt == '0)
        else $error("periodic dividers kept in wait");

    watchdog_hold_a: assert property (
        pseudo_stop && !s.watchdog_pseudo_stop_enable && !mode_i.wait_mode
        |-> !watchdog_run_o && !watchdog_init_o)
        else $error("watchdog running or reset in pseudo-stop");

    count_bound_a: assert property (
        s.modulus_cnt <= modulus && s.prescale_cnt <= prescale_last)
        else $error("periodic counter past its limit");

    off_cleared_a: assert property (
        prescale == PRESCALE_OFF |=> s.prescale_cnt == '0 && s.modulus_cnt == '0)
        else $error("periodic counter moved while off");

    flag_clear_a: assert property (
        wr && idx == TIMER_STATUS_IDX && wdata[STAT_FLAG_BIT] && !next_s.periodic_tick
        |=> !periodic_flag_o)
        else $error("periodic flag not cleared");

endmodule

// >>> tb/pcpt_core_tb.sv
// self-checking bench for the loop control and periodic timer block
module pcpt_core_tb
    import pcpt_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int LIMIT = 60000;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    pcpt_wb_req_t wb = '0;
    pcpt_mode_t mode = '0;
    logic osc_slow = 1'b0;
    logic near = 1'b0;
    logic wb_ack_o, cm_act, mon_rst, scm_act, osc_en, osc_low, pwr, auto_lock, high_bw;
    logic [31:0] wb_dat_o;
    logic p_run, p_tick, p_flag, wd_run, wd_init;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc_count = 0;
    int n, x;
    logic [7:0] rates [3] = '{8'h10, 8'h12, 8'h20};
    int per [3] = '{1024, 3072, 2048};

    pcpt_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_ack_o(wb_ack_o),
        .wb_dat_o(wb_dat_o), .mode_i(mode), .osc_slow_i(osc_slow), .target_near_i(near),
        .clock_monitor_active_o(cm_act), .monitor_reset_o(mon_rst),
        .self_clock_active_o(scm_act), .oscillator_enable_o(osc_en),
        .oscillator_low_amplitude_o(osc_low), .loop_power_o(pwr),
        .loop_auto_lock_o(auto_lock), .loop_high_bandwidth_o(high_bw),
        .periodic_run_o(p_run), .periodic_tick_o(p_tick), .periodic_flag_o(p_flag),
        .watchdog_run_o(wd_run), .watchdog_init_o(wd_init));

    always #2.5 clk_i = ~clk_i;

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // a hang ends the run through the same verdict
    always @(posedge clk_i) begin
        cyc_count <= cyc_count + 1;
        if (cyc_count == LIMIT) begin
            bad_count++;
            print_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // outputs are read right after an edge, so they carry the value sampled at that edge
    task automatic wb_xfer(input logic we, input logic [5:0] idx, input logic [7:0] wd,
                           output logic [31:0] rd);
        @(posedge clk_i);
        wb.cyc <= 1'b1;
        wb.stb <= 1'b1;
        wb.we <= we;
        wb.adr <= {idx, 2'b00};
        wb.sel <= 4'h1;
        wb.dat <= {24'h000000, wd};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb.cyc <= 1'b0;
        wb.stb <= 1'b0;
        wb.we <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [31:0] r;
        wb_xfer(1'b1, idx, d, r);
    endtask

    // the whole word is compared: the upper lanes must read zero
    task automatic rd_chk(input logic [5:0] idx, input logic [7:0] e);
        logic [31:0] r;
        wb_xfer(1'b0, idx, 8'h00, r);
        chk(r, {24'h000000, e});
    endtask

    task automatic wait_cyc(input int c);
        repeat (c) @(posedge clk_i);
    endtask

    task automatic tick_gap(output int c);
        c = 0;
        do begin
            @(posedge clk_i);
            c++;
        end while (p_tick !== 1'b1);
    endtask

    initial begin
        wait_cyc(4);
        rst_i <= 1'b0;
        wait_cyc(2);
        rd_chk(LOOP_CONTROL_IDX, LOOP_CONTROL_RST);
        rd_chk(PERIODIC_RATE_IDX, 8'h00);
        rd_chk(6'h3f, 8'h00);
        chk(p_run, 1'b0);
        wr(PERIODIC_RATE_IDX, 8'h7f);
        rd_chk(PERIODIC_RATE_IDX, 8'h7f);
        wr(PERIODIC_RATE_IDX, 8'h0f);
        chk(p_run, 1'b0);
        wait_cyc(1500);
        chk(p_flag, 1'b0);
        $display("test reset and off done");
        // only the short prescale codes fit the run length
        for (int i = 0; i < 3; i++) begin
            wr(PERIODIC_RATE_IDX, rates[i]);
            tick_gap(x);
            tick_gap(n);
            chk(n, per[i]);
        end
        chk(p_flag, 1'b1);
        wr(TIMER_STATUS_IDX, 8'h01);
        rd_chk(TIMER_STATUS_IDX, 8'h00);
        $display("test periods done");
        wr(PERIODIC_RATE_IDX, 8'h10);
        tick_gap(x);
        wait_cyc(500);
        wr(PERIODIC_RATE_IDX, 8'h10);
        tick_gap(n);
        chk(n >= 1020 && n <= 1030, 1'b1);
        // a pause in pseudo-stop must lengthen the period by its own length only
        tick_gap(x);
        wait_cyc(199);
        mode <= '{stop_mode: 1'b1, pseudo_stop_select: 1'b1, default: 1'b0};
        wait_cyc(2);
        chk(p_run, 1'b0);
        chk(wd_run, 1'b0);
        chk(wd_init, 1'b0);
        chk(cm_act, 1'b1);
        chk(osc_low, 1'b1);
        wait_cyc(298);
        mode.stop_mode <= 1'b0;
        tick_gap(n);
        chk(n + 499 >= 1322 && n + 499 <= 1326, 1'b1);
        wr(LOOP_CONTROL_IDX, 8'hf7);
        mode.stop_mode <= 1'b1;
        wait_cyc(1);
        chk(p_run, 1'b1);
        chk(wd_run, 1'b1);
        mode.pseudo_stop_select <= 1'b0;
        wait_cyc(1);
        chk(cm_act, 1'b0);
        chk(osc_en, 1'b0);
        mode <= '{wait_mode: 1'b1, watchdog_stop_in_wait: 1'b1,
            periodic_timer_stop_in_wait: 1'b1, default: 1'b0};
        wait_cyc(1);
        chk({wd_init, wd_run}, 2'b10);
        chk(p_run, 1'b0);
        mode <= '0;
        // wait-mode stop reinitialises: one cleared cycle, then a full period
        tick_gap(n);
        chk(n, 1025);
        $display("test low power done");
        mode <= '{loop_clock_select: 1'b1, default: 1'b0};
        wr(LOOP_CONTROL_IDX, 8'hb1);
        // pseudo-stop enables are writable anytime, only the on bit is refused
        rd_chk(LOOP_CONTROL_IDX, 8'hf1);
        chk(pwr, 1'b1);
        mode.loop_clock_select <= 1'b0;
        wr(LOOP_CONTROL_IDX, 8'hb1);
        rd_chk(LOOP_CONTROL_IDX, 8'hb1);
        chk(pwr, 1'b0);
        mode.loop_stop_in_wait <= 1'b1;
        wr(LOOP_CONTROL_IDX, 8'hd1);
        rd_chk(LOOP_CONTROL_IDX, 8'hf1);
        mode.loop_stop_in_wait <= 1'b0;
        wr(LOOP_CONTROL_IDX, 8'hd1);
        rd_chk(LOOP_CONTROL_IDX, 8'hd1);
        chk({high_bw, auto_lock}, 2'b10);
        wr(LOOP_CONTROL_IDX, 8'hc1);
        chk(high_bw, 1'b0);
        wr(LOOP_CONTROL_IDX, 8'hf1);
        near <= 1'b1;
        wait_cyc(1);
        chk({high_bw, auto_lock}, 2'b01);
        near <= 1'b0;
        wait_cyc(1);
        chk(high_bw, 1'b1);
        $display("test loop bits done");
        wr(LOOP_CONTROL_IDX, 8'hb1);
        osc_slow <= 1'b1;
        wait_cyc(4);
        chk({scm_act, mon_rst, pwr}, 3'b101);
        wr(LOOP_CONTROL_IDX, 8'h34);
        rd_chk(LOOP_CONTROL_IDX, 8'hb5);
        // the timer has kept ticking since the flag was cleared
        rd_chk(TIMER_STATUS_IDX, 8'h03);
        osc_slow <= 1'b0;
        wait_cyc(4);
        chk(scm_act, 1'b0);
        mode.special_mode <= 1'b1;
        wr(LOOP_CONTROL_IDX, 8'hb0);
        rd_chk(LOOP_CONTROL_IDX, 8'hb0);
        mode.special_mode <= 1'b0;
        wr(LOOP_CONTROL_IDX, 8'hb1);
        rd_chk(LOOP_CONTROL_IDX, 8'hb0);
        osc_slow <= 1'b1;
        wait_cyc(4);
        chk({scm_act, mon_rst}, 2'b01);
        osc_slow <= 1'b0;
        wait_cyc(4);
        $display("test clock failure done");
        print_verdict();
    end
endmodule
